// ==== hdl/sfh_parser.sv ====
// speech frame header parser: rate from length, serial field decode
`timescale 1ns/1ps
module sfh_parser
  import sfh_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // frame stream from depacketizer
  input  wire logic           frm_start,
  input  wire logic [9:0]     frm_bits,
  input  wire logic           bit_vld,
  input  wire logic           bit_dat,
  // decoded header
  output logic                hdr_vld_ff,
  output logic                unsup_ff,
  output sfh_fields_type      fields_ff
);

  sfh_state_type   state_ff, nxt_state;
  logic [2:0]      cnt_ff, nxt_cnt;
  logic [7:0]      shf_ff, nxt_shf;
  logic [9:0]      len_ff, nxt_len;
  logic            nxt_hdr_vld, nxt_unsup;
  sfh_fields_type  nxt_fields;

  // length to rate; anything else is unsupported
  function automatic sfh_rate_type rate_of(input logic [9:0] n);
    case (n)
      LEN_LOW:  rate_of = RATE_LOW;
      LEN_7K2:  rate_of = RATE_7K2;
      LEN_8K0:  rate_of = RATE_8K0;
      LEN_9K6:  rate_of = RATE_9K6;
      LEN_13K2: rate_of = RATE_13K2;
      LEN_16K4: rate_of = RATE_16K4;
      LEN_24K4: rate_of = RATE_24K4;
      default:  rate_of = RATE_NONE;
    endcase
  endfunction : rate_of

  // field decode; b[7] is the first bit received
  function automatic sfh_fields_type decode(input logic [9:0] n, input logic [7:0] b);
    sfh_fields_type f;
    f = FIELDS_RST;
    f.rate = rate_of(n);
    case (f.rate)
      RATE_LOW: begin
        f.coder_type_index    = {1'b0, b[7:5]};
        f.lowrate_active      = b[7];
        f.noise_excited_frame = b[6];
        f.bandwidth_index     = {1'b0, b[5]};            // narrow or wide
        f.hdr_len             = HL_3;
      end
      RATE_7K2, RATE_8K0: begin
        f.joint_index = {1'b0, b[7:4]};
        f.core        = b[7] ? CORE_HQ : CORE_PRED;
        f.hdr_len     = HL_4;
      end
      RATE_9K6: begin
        f.bandwidth_index  = b[7:6];
        f.coder_type_index = {1'b0, b[5:3]};
        f.core             = b[5] ? CORE_TCX : CORE_PRED;
        f.hdr_len          = HL_5;
      end
      RATE_13K2: begin
        f.joint_index     = b[7:3];
        f.redundancy_flag = b[3];
        if (b[7]) begin
          // transform family: select bit, then sub-type for the excited core
          if (b[2]) begin
            f.core                    = CORE_TCX;
            f.transform_coder_subtype = b[1:0];
            f.hdr_len                 = HL_8;
          end else begin
            f.core    = CORE_HQ;
            f.hdr_len = HL_6;
          end
        end else if (b[6]) begin
          f.ext     = b[2] ? EXT_FREQ : EXT_TIME;
          f.hdr_len = HL_6;
        end else begin
          f.hdr_len = HL_5;
        end
      end
      RATE_16K4: begin
        f.bandwidth_index = b[7:6];
        f.redundancy_flag = b[5];                        // reserved
        case (b[4:3])
          2'b00: begin
            f.core             = CORE_HQ;
            f.coder_type_index = {2'b00, b[4:3]};
            f.hdr_len          = HL_5;
          end
          2'b11: begin
            f.core             = CORE_TCX;
            f.coder_type_index = b[4:1];
            f.hdr_len          = HL_7;
          end
          default: begin
            f.coder_type_index = {1'b0, b[4:2]};
            f.hdr_len          = HL_6;
          end
        endcase
      end
      RATE_24K4: begin
        f.bandwidth_index = b[7:6];
        f.redundancy_flag = b[5];                        // reserved
        if (b[4]) begin
          if (b[3]) begin
            f.core                    = CORE_TCX;
            f.transform_coder_subtype = b[2:1];
            f.hdr_len                 = HL_7;
          end else begin
            f.core          = CORE_HQ;
            f.prev_was_pred = b[2];
            f.int_rate_16k  = b[2] & b[1];
            f.hdr_len       = b[2] ? HL_7 : HL_6;
          end
        end else begin
          f.coder_type_index = {2'b00, b[3:2]};
          f.hdr_len          = HL_6;
        end
      end
      default: f.hdr_len = '0;
    endcase
    // extension bits are not split off; downstream knows their size
    f.core_bits = n - {6'h00, f.hdr_len};
    return f;
  endfunction : decode

  // next state: collect the header window, then emit once
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_shf     = shf_ff;
    nxt_len     = len_ff;
    nxt_hdr_vld = 1'b0;
    nxt_unsup   = 1'b0;
    nxt_fields  = fields_ff;
    // a new frame aborts any header still being collected
    if (frm_start) begin
      nxt_cnt = '0;
      nxt_len = frm_bits;
      if (rate_of(frm_bits) == RATE_NONE) begin
        nxt_unsup = 1'b1;
        nxt_state = ST_IDLE;
      end else begin
        nxt_state = ST_COLL;
      end
    end else begin
      case (state_ff)
        ST_IDLE: nxt_state = ST_IDLE;
        ST_COLL: begin
          if (bit_vld) begin
            nxt_shf = {shf_ff[6:0], bit_dat};
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == CNT_LAST) begin
              nxt_fields  = decode(len_ff, {shf_ff[6:0], bit_dat});
              nxt_hdr_vld = 1'b1;
              nxt_state   = ST_IDLE;
            end
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= '0;
      shf_ff     <= '0;
      len_ff     <= '0;
      hdr_vld_ff <= 1'b0;
      unsup_ff   <= 1'b0;
      fields_ff  <= FIELDS_RST;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      shf_ff     <= nxt_shf;
      len_ff     <= nxt_len;
      hdr_vld_ff <= nxt_hdr_vld;
      unsup_ff   <= nxt_unsup;
      fields_ff  <= nxt_fields;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_unsup_no_fields: assert property (unsup_ff |-> !hdr_vld_ff && $stable(fields_ff))
    else $error("unsupported frame produced fields");
  a_msb_first_emit: assert property (state_ff == ST_COLL && !frm_start && bit_vld && cnt_ff == CNT_LAST
    |=> hdr_vld_ff && shf_ff[0] == $past(bit_dat))
    else $error("header not emitted after last window bit");
  a_rate_from_len: assert property (hdr_vld_ff && fields_ff.core_bits + fields_ff.hdr_len == LEN_9K6
    |-> fields_ff.rate == RATE_9K6)
    else $error("192 bit frame not at 9.6 rate");
  a_low_layout: assert property (hdr_vld_ff && fields_ff.rate == RATE_LOW
    |-> fields_ff.hdr_len == HL_3 && fields_ff.core_bits == 10'h035)
    else $error("low rate layout wrong");
  a_vbr_accept: assert property (frm_start && (frm_bits == LEN_LOW || frm_bits == LEN_7K2)
    |=> !unsup_ff ##1 state_ff == ST_COLL)
    else $error("variable rate frame refused");
  a_joint_core: assert property (hdr_vld_ff && (fields_ff.rate == RATE_7K2 || fields_ff.rate == RATE_8K0)
    |-> (fields_ff.core == CORE_HQ) == fields_ff.joint_index[3])
    else $error("joint index core mismatch");
  a_ct_core: assert property (hdr_vld_ff && fields_ff.rate == RATE_9K6
    |-> (fields_ff.core == CORE_TCX) == fields_ff.coder_type_index[2])
    else $error("9.6 core not from coder type");
  a_joint_family: assert property (hdr_vld_ff && fields_ff.rate == RATE_13K2
    |-> (fields_ff.core == CORE_PRED) == !fields_ff.joint_index[4])
    else $error("264 joint index family mismatch");
  a_excited_len: assert property (hdr_vld_ff && fields_ff.rate == RATE_13K2 && fields_ff.core == CORE_TCX
    |-> fields_ff.hdr_len == HL_8)
    else $error("sub-type bits missing at 264");
  a_ext_len: assert property (hdr_vld_ff && fields_ff.rate == RATE_13K2 && fields_ff.ext != EXT_NONE
    |-> fields_ff.hdr_len == HL_6)
    else $error("extension flag length wrong");
  a_ct_span: assert property (hdr_vld_ff && fields_ff.rate == RATE_16K4
    |-> fields_ff.hdr_len >= HL_5 && fields_ff.hdr_len <= HL_7)
    else $error("16.4 coder type width wrong");
  a_prev_core: assert property (hdr_vld_ff && fields_ff.rate == RATE_24K4 && fields_ff.core == CORE_HQ
    |-> fields_ff.hdr_len == (fields_ff.prev_was_pred ? HL_7 : HL_6))
    else $error("previous core bits wrong");

  c_low_frame: cover property (hdr_vld_ff && fields_ff.rate == RATE_LOW && fields_ff.lowrate_active);
  c_tcx_264: cover property (hdr_vld_ff && fields_ff.rate == RATE_13K2 && fields_ff.core == CORE_TCX);
  c_hq_prev: cover property (hdr_vld_ff && fields_ff.core == CORE_HQ && fields_ff.int_rate_16k);
  c_unsup: cover property (unsup_ff);

endmodule : sfh_parser

// ==== hdl/sfh_pkg.sv ====
// constants, types and decode layouts of the speech frame header parser
// Functional notes
// - every field is shifted in and decoded most significant bit first
// - 144, 160 and 192 bit frames select the 7.2, 8.0 and 9.6 layouts
// - 56 bit frames: 3-bit coder type, active flag then variant, 53 core bits
// - variable rate mode accepts prototype, noise-excited and 7.2 frames
// - at 7.2 and 8.0 a joint index also picks predictive or transform core
// - at 9.6 the core choice comes from inside the coder type field
// - 264 bit frames: 5-bit joint index, also tells predictive or transform
// - at 264 a transform core is followed by one core select bit
// - at 264 the transform-excited core carries a 2-bit sub-type
// - at 264 predictive frames with extension carry a time/frequency flag
// - 328 bits: 2-bit bandwidth, reserved flag, coder type of 2 to 4 bits
// - 488 bits: 2-bit bandwidth, reserved flag, core family flag
// - transform family flag is followed by the transform core select bit
// - transform-excited core is followed by a 2-bit sub-type
// - high quality core: previous-core bit, internal rate bit only if set
package sfh_pkg;

  // frame lengths in bits
  localparam logic [9:0] LEN_LOW  = 10'h038;
  localparam logic [9:0] LEN_7K2  = 10'h090;
  localparam logic [9:0] LEN_8K0  = 10'h0A0;
  localparam logic [9:0] LEN_9K6  = 10'h0C0;
  localparam logic [9:0] LEN_13K2 = 10'h108;
  localparam logic [9:0] LEN_16K4 = 10'h148;
  localparam logic [9:0] LEN_24K4 = 10'h1E8;

  // header window: longest header is 8 bits
  localparam int         HDR_WIN  = 8;
  localparam logic [2:0] CNT_LAST = 3'h7;

  // header lengths
  localparam logic [3:0] HL_3 = 4'h3;
  localparam logic [3:0] HL_4 = 4'h4;
  localparam logic [3:0] HL_5 = 4'h5;
  localparam logic [3:0] HL_6 = 4'h6;
  localparam logic [3:0] HL_7 = 4'h7;
  localparam logic [3:0] HL_8 = 4'h8;

  typedef enum logic [2:0] {
    RATE_LOW = 3'h0, RATE_7K2 = 3'h1, RATE_8K0 = 3'h2, RATE_9K6 = 3'h3,
    RATE_13K2 = 3'h4, RATE_16K4 = 3'h5, RATE_24K4 = 3'h6, RATE_NONE = 3'h7
  } sfh_rate_type;

  typedef enum logic [1:0] {
    CORE_PRED = 2'h0, CORE_HQ = 2'h1, CORE_TCX = 2'h2
  } sfh_core_type;

  typedef enum logic [1:0] {
    EXT_NONE = 2'h0, EXT_TIME = 2'h1, EXT_FREQ = 2'h2
  } sfh_ext_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_COLL = 2'b01
  } sfh_state_type;

  typedef struct packed {
    sfh_rate_type rate;
    sfh_core_type core;
    sfh_ext_type  ext;
    logic [1:0]   bandwidth_index;
    logic [3:0]   coder_type_index;
    logic [4:0]   joint_index;
    logic         redundancy_flag;
    logic         lowrate_active;
    logic         noise_excited_frame;
    logic [1:0]   transform_coder_subtype;
    logic         prev_was_pred;
    logic         int_rate_16k;
    logic [3:0]   hdr_len;
    logic [9:0]   core_bits;
  } sfh_fields_type;

  localparam sfh_fields_type FIELDS_RST = '{rate: RATE_NONE, core: CORE_PRED, ext: EXT_NONE,
                                           default: '0};

endpackage : sfh_pkg

// ==== tb/sfh_parser_tb_top.sv ====
// self-checking bench of the speech frame header parser
`timescale 1ns/1ps
module sfh_parser_tb_top import sfh_pkg::*; ();
  typedef struct {
    logic unsup; logic [9:0] len; logic [7:0] hdr; sfh_rate_type rate; sfh_core_type core;
    sfh_ext_type ext; logic [1:0] bw; logic [1:0] sub; logic [3:0] hl; logic prv;
    logic cb; logic cs; logic ch; logic rf; logic [3:0] ct; logic [4:0] jt;
  } sfh_exp_type;
  logic clk, rst, frm_start, bit_vld, bit_dat, hdr_vld_ff, unsup_ff;
  logic [9:0] frm_bits;
  sfh_fields_type fields_ff;
  sfh_exp_type q[$];
  sfh_exp_type e;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [9:0] lens [7] = '{LEN_LOW, LEN_7K2, LEN_8K0, LEN_9K6, LEN_13K2, LEN_16K4, LEN_24K4};
  logic [17:0] dir [19] = '{{LEN_LOW, 8'hA0}, {LEN_LOW, 8'hC0}, {LEN_7K2, 8'h80}, {LEN_7K2, 8'h30},
    {LEN_8K0, 8'h90}, {LEN_9K6, 8'h24}, {LEN_9K6, 8'h40}, {LEN_13K2, 8'h87}, {LEN_13K2, 8'h80},
    {LEN_13K2, 8'h44}, {LEN_13K2, 8'h40}, {LEN_13K2, 8'h10}, {LEN_16K4, 8'h20}, {LEN_16K4, 8'h18},
    {LEN_16K4, 8'h08}, {LEN_24K4, 8'h1A}, {LEN_24K4, 8'h16}, {LEN_24K4, 8'h10}, {LEN_24K4, 8'hC0}};
  logic [9:0] bad_len [4] = '{10'h064, 10'h037, 10'h039, 10'h3FF};

  sfh_src_model u_src (.clk(clk), .frm_start(frm_start), .frm_bits(frm_bits), .bit_vld(bit_vld),
                       .bit_dat(bit_dat));
  sfh_parser uut (.clk(clk), .rst(rst), .frm_start(frm_start), .frm_bits(frm_bits), .bit_vld(bit_vld),
                  .bit_dat(bit_dat), .hdr_vld_ff(hdr_vld_ff), .unsup_ff(unsup_ff), .fields_ff(fields_ff));

  // expected decode from length and the first eight bits
  function automatic sfh_exp_type calc(input logic [9:0] n, input logic [7:0] h);
    sfh_exp_type x;
    x = '{unsup: 1'b0, len: n, hdr: h, rate: RATE_NONE, core: CORE_PRED, ext: EXT_NONE, bw: h[7:6],
          sub: h[1:0], hl: 4'h0, prv: h[2], default: '0};
    case (n)
      LEN_LOW: begin
        x.rate = RATE_LOW;
        x.hl   = HL_3;
        x.bw   = {1'b0, h[5]};
        x.ct   = {1'b0, h[7:5]};
        x.cb   = 1'b1;
      end
      LEN_7K2, LEN_8K0: begin
        x.rate = (n == LEN_7K2) ? RATE_7K2 : RATE_8K0;
        x.core = h[7] ? CORE_HQ : CORE_PRED;
        x.jt   = {1'b0, h[7:4]};
        x.hl   = HL_4;
      end
      LEN_9K6: begin
        x.rate = RATE_9K6;
        x.core = h[5] ? CORE_TCX : CORE_PRED;
        x.ct   = {1'b0, h[5:3]};
        x.hl   = HL_5;
        x.cb   = 1'b1;
      end
      LEN_13K2: begin
        x.rate = RATE_13K2; x.hl = HL_5; x.cs = 1'b1;
        x.jt   = h[7:3];
        x.rf   = h[3];
        if (h[7]) begin x.core = h[2] ? CORE_TCX : CORE_HQ; x.hl = h[2] ? HL_8 : HL_6; end
        else if (h[6]) begin x.ext = h[2] ? EXT_FREQ : EXT_TIME; x.hl = HL_6; end
      end
      LEN_16K4: begin
        x.rate = RATE_16K4; x.cb = 1'b1; x.hl = HL_6;
        x.rf   = h[5];
        x.ct   = {1'b0, h[4:2]};
        if (h[4:3] == 2'b00) begin x.core = CORE_HQ; x.hl = HL_5; x.ct = 4'h0; end
        else if (h[4:3] == 2'b11) begin x.core = CORE_TCX; x.hl = HL_7; x.ct = h[4:1]; end
      end
      LEN_24K4: begin
        x.rate = RATE_24K4; x.cb = 1'b1; x.cs = 1'b1;
        x.rf   = h[5];
        if (h[4] && h[3]) begin x.core = CORE_TCX; x.sub = h[2:1]; x.hl = HL_7; end
        else if (h[4]) begin x.core = CORE_HQ; x.ch = 1'b1; x.hl = h[2] ? HL_7 : HL_6; end
        // predictive: bandwidth, reserved, family flag and a 2-bit coder type
        else begin x.ct = {2'b00, h[3:2]}; x.hl = HL_6; end
      end
      default: x.unsup = 1'b1;
    endcase
    return x;
  endfunction : calc

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // note first, then send; the monitor pairs results in order
  task automatic go(input logic [9:0] n, input logic [7:0] h, input int nb, input bit st);
    q.push_back(calc(n, h));
    u_src.send(n, h, nb, st, 1'b1);
  endtask : go

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end

  // result monitor: every pulse takes the oldest note
  always @(posedge clk) begin
    if (!rst && (hdr_vld_ff === 1'b1 || unsup_ff === 1'b1)) begin
      if (q.size() == 0) chk("spurious pulse", 16'h0001, 16'h0000);
      else begin
        e = q.pop_front();
        chk("unsup_ff", unsup_ff, e.unsup);
        chk("hdr_vld_ff", hdr_vld_ff, !e.unsup);
        if (!e.unsup) begin
          chk("rate", fields_ff.rate, e.rate);
          chk("core", fields_ff.core, e.core);
          if (e.rate == RATE_13K2) chk("ext", fields_ff.ext, e.ext);
          if (e.cb) chk("bandwidth_index", fields_ff.bandwidth_index, e.bw);
          chk("coder_type_index", fields_ff.coder_type_index, e.ct);
          chk("joint_index", fields_ff.joint_index, e.jt);
          chk("redundancy_flag", fields_ff.redundancy_flag, e.rf);
          if (e.rate == RATE_LOW) begin
            chk("lowrate_active", fields_ff.lowrate_active, e.hdr[7]);
            chk("noise_excited_frame", fields_ff.noise_excited_frame, e.hdr[6]);
          end
          if (e.hl != 4'h0) begin
            chk("hdr_len", fields_ff.hdr_len, e.hl);
            chk("core_bits", fields_ff.core_bits, e.len - 10'(e.hl));
          end
          if (e.cs && e.core == CORE_TCX) chk("subtype", fields_ff.transform_coder_subtype, e.sub);
          if (e.ch) chk("prev_was_pred", fields_ff.prev_was_pred, e.prv);
          if (e.ch) chk("int_rate_16k", fields_ff.int_rate_16k, e.prv & e.hdr[1]);
        end
      end
    end
  end

  // main sequence
  initial begin
    int k;
    rst = 1'b1;
    void'($urandom(32'ha0a7));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset rate", fields_ff.rate, RATE_NONE);
    chk("reset hdr_vld_ff", hdr_vld_ff, 1'b0);
    // stray bits before any frame must be ignored
    u_src.send(10'h000, 8'hFF, 5, 1'b0, 1'b0);
    for (k = 0; k < 19; k++) go(dir[k][17:8], dir[k][7:0], 12, k[0]);
    // bits after an unsupported start must not yield a decode
    for (k = 0; k < 4; k++) go(bad_len[k], 8'hFF, 10, 1'b0);
    // abort in mid-header, then three frames back to back
    u_src.send(LEN_24K4, 8'h18, 4, 1'b0, 1'b1);
    go(LEN_9K6, 8'h64, 8, 1'b0);
    go(LEN_13K2, 8'h86, 8, 1'b0);
    go(LEN_LOW, 8'hE0, 9, 1'b0);
    repeat (40) begin
      k = $urandom_range(6);
      go(lens[k], 8'($urandom), 8 + $urandom_range(24), 1'($urandom_range(1)));
    end
    repeat (12) @(posedge clk);
    chk("pending notes", 16'(q.size()), 16'h0000);
    results();
  end
endmodule : sfh_parser_tb_top

// ==== tb/sfh_src_model.sv ====
// depacketizer model: frame start, length and header bits
`timescale 1ns/1ps
module sfh_src_model (
  // clock
  input  wire logic       clk,
  // frame stream
  output logic            frm_start,
  output logic [9:0]      frm_bits,
  output logic            bit_vld,
  output logic            bit_dat
);
  initial begin
    frm_start = 1'b0;
    frm_bits  = 10'h000;
    bit_vld   = 1'b0;
    bit_dat   = 1'b0;
  end

  // one frame; nb of 8 leaves the line up so a next frame starts back to back
  task automatic send(input logic [9:0] n, input logic [7:0] h, input int nb, input bit st, input bit fs);
    int i;
    i = 0;
    if (fs) begin
      @(posedge clk);
      frm_start <= 1'b1;
      frm_bits  <= n;
      bit_vld   <= 1'b0;
    end
    while (i < nb) begin
      @(posedge clk);
      frm_start <= 1'b0;
      frm_bits  <= ~n;
      // stalls show a toggled line so stale data never looks valid
      if (st && $urandom_range(2) == 0) begin
        bit_vld <= 1'b0;
        bit_dat <= ~bit_dat;
      end else begin
        bit_vld <= 1'b1;
        bit_dat <= (i < 8) ? h[7 - i] : 1'($urandom_range(1));
        i++;
      end
    end
    if (nb != 8) begin
      @(posedge clk);
      frm_start <= 1'b0;
      bit_vld   <= 1'b0;
      bit_dat   <= ~bit_dat;
    end
  endtask : send
endmodule : sfh_src_model
